/* verilog/cmpfl_pkg.sv */
// Package: register map, field positions and timing for the comparator flag block
package cmpfl_pkg;
  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four, so index times four
  localparam logic [7:0] PORT_B_DIRECTION_IDX = 8'h05;
  localparam logic [7:0] PULLDOWN_REG_IDX = 8'h11;
  localparam logic [7:0] ANALOG_STATUS_IDX = 8'h20;
  localparam logic [7:0] ANALOG_CONTROL_IDX = 8'h21;
  localparam logic [7:0] ANALOG_SELECT_IDX = 8'h22;
  localparam logic [7:0] PORT_B_DATA_IDX = 8'h23;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h24;
  localparam logic [7:0] OPTION_IDX = 8'h25;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Status: flags, live outputs, flag clears (write one)
  localparam int ST_FLAG1 = 0;
  localparam int ST_FLAG2 = 1;
  localparam int ST_LIVE1 = 2;
  localparam int ST_LIVE2 = 3;
  localparam int ST_CLR1 = 4;
  localparam int ST_CLR2 = 5;
  // Control
  localparam int CT_PWR1 = 0;
  localparam int CT_PWR2 = 1;
  localparam int CT_CAPT = 2;
  localparam int CT_PINEN = 3;
  // Select
  localparam int SEL_INV = 0;
  localparam int SEL_DIVIDER_HOLD = 1;
  // Shared pin position in port B
  localparam int SHARED_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PD_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 2;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

  // Analog-side control bundle
  typedef struct packed {
    logic pwr_one;
    logic pwr_two;
    logic bias_on;
    logic invert;
    logic divider_on;
  } cmpfl_analog_t;
endpackage

/* verilog/cmpfl_edge_flag.sv */
// Synchronised rising-edge detector with a sticky write-one-clear flag
`timescale 1ns/1ps
`default_nettype none
module cmpfl_edge_flag (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  input wire logic clear_i,
  output logic flag_o
);
  // ----------------------------------------------------------------
  // Synchroniser and edge
  // ----------------------------------------------------------------
  logic meta_q; // First stage, read only by sync_q
  logic sync_q; // Second stage
  logic last_q; // Previous synchronised level
  logic rise;   // One-cycle rising edge

  // Two-flop synchroniser; the analog output is fully asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= level_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;

  // Set wins over clear so an edge in the clear cycle is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (rise) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_edge_sets;
    @(posedge clk_i) disable iff (!rst_n_i) rise |=> flag_o;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i) flag_o && !clear_i |=> flag_o;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_sync_delay;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(sync_q) |-> rise ##1 flag_o;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync edge lost");
endmodule
`default_nettype wire

/* verilog/cmpfl_top.sv */
// Comparator flag, live status and shared pin OR logic with APB registers
//
// Contract
// - Rising comparator output sets sticky flag
// - Flag clears by write-one or reset
// - Flags raise analog irq; two triggers capture
// - Status shows unsynchronised live outputs
// - Config writes may set flags
// - Comparator settles within 2 us
// - Power per enable; bias when any on
// - Output pin is OR of three sources
// - Pulldown off while pin is output
// - Comparator term needs enable and option
// - Divider connected only with divider hold
// - Invert swaps inputs and inverts outputs
`timescale 1ns/1ps
`default_nettype none
module cmpfl_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Raw comparator outputs from the analog core, asynchronous
  input wire logic cmp_one_raw_i,
  input wire logic cmp_two_raw_i,
  // Timer output-compare level, same clock
  input wire logic compare_output_level_i,
  // Analog control bundle
  output cmpfl_pkg::cmpfl_analog_t analog_o,
  // Shared output pin, enable low while driving
  output logic shared_output_pin_o,
  output logic shared_output_pin_oe_n_o,
  // Port B pulldown enables, one per pin
  output logic [7:0] pulldown_on_o,
  // Interrupt and capture trigger
  output logic analog_irq_o,
  output logic capture_trigger_o,
  // Settled indication: comparator stable after power or flag change
  output logic settled_o
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q; // First stage, read only by rst_sync_q
  logic rst_sync_q; // Released reset for the design
  logic rst_n;

  // Asynchronous assert, synchronous release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] direction_q; // Port B direction
  logic [7:0] pd_inhibit_q; // Pulldown inhibit, write only
  logic [7:0] control_q; // Power, capture route, pin enable
  logic [7:0] select_q; // Invert, divider hold
  logic [7:0] port_data_q; // Port B data
  logic [1:0] mask_q; // Interrupt mask
  logic option_q; // Analog options mask option
  logic flag_one;
  logic flag_two;
  logic clr_one;
  logic clr_two;
  logic live_one;
  logic live_two;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access; // Access phase
  logic wr;
  logic [7:0] idx; // Word index
  logic hit;

  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign idx = paddr_i[9:2];

  // Mapped index check, shared by read and error paths
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == cmpfl_pkg::PORT_B_DIRECTION_IDX) || (i == cmpfl_pkg::PULLDOWN_REG_IDX) ||
             (i == cmpfl_pkg::ANALOG_STATUS_IDX) || (i == cmpfl_pkg::ANALOG_CONTROL_IDX) ||
             (i == cmpfl_pkg::ANALOG_SELECT_IDX) || (i == cmpfl_pkg::PORT_B_DATA_IDX) ||
             (i == cmpfl_pkg::IRQ_MASK_IDX) || (i == cmpfl_pkg::OPTION_IDX);
  endfunction

  assign hit = mapped(idx) && (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);

  // Write-one pulses to clear each flag
  assign clr_one = wr && hit && (idx == cmpfl_pkg::ANALOG_STATUS_IDX) &&
                   pwdata_i[cmpfl_pkg::ST_CLR1];
  assign clr_two = wr && hit && (idx == cmpfl_pkg::ANALOG_STATUS_IDX) &&
                   pwdata_i[cmpfl_pkg::ST_CLR2];

  // Writable registers; a config write may let an analog edge set a flag
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      direction_q <= cmpfl_pkg::REG_RESET;
      pd_inhibit_q <= cmpfl_pkg::PD_RESET;
      control_q <= cmpfl_pkg::REG_RESET;
      select_q <= cmpfl_pkg::REG_RESET;
      port_data_q <= cmpfl_pkg::REG_RESET;
      mask_q <= 2'b00;
      option_q <= 1'b0;
    end else if (wr && hit) begin
      case (idx)
        cmpfl_pkg::PORT_B_DIRECTION_IDX: begin
          direction_q <= pwdata_i[7:0];
        end
        cmpfl_pkg::PULLDOWN_REG_IDX: begin
          pd_inhibit_q <= pwdata_i[7:0];
        end
        cmpfl_pkg::ANALOG_CONTROL_IDX: begin
          control_q <= {4'h0, pwdata_i[3:0]};
        end
        cmpfl_pkg::ANALOG_SELECT_IDX: begin
          select_q <= {6'h00, pwdata_i[1:0]};
        end
        cmpfl_pkg::PORT_B_DATA_IDX: begin
          port_data_q <= pwdata_i[7:0];
        end
        cmpfl_pkg::IRQ_MASK_IDX: begin
          mask_q <= pwdata_i[1:0];
        end
        cmpfl_pkg::OPTION_IDX: begin
          option_q <= pwdata_i[0];
        end
        default: begin
          // Status has no stored bits
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Live outputs carry the invert; hardware swaps the inputs as well
  assign live_one = cmp_one_raw_i ^ select_q[cmpfl_pkg::SEL_INV];
  assign live_two = cmp_two_raw_i ^ select_q[cmpfl_pkg::SEL_INV];

  cmpfl_edge_flag u_flag_one (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .level_i(live_one),
    .clear_i(clr_one),
    .flag_o(flag_one)
  );

  cmpfl_edge_flag u_flag_two (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .level_i(live_two),
    .clear_i(clr_two),
    .flag_o(flag_two)
  );

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Zero wait states; read data registered in the setup cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~hit;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && hit) begin
        case (idx)
          cmpfl_pkg::PORT_B_DIRECTION_IDX: begin
            prdata_o <= {24'h00_0000, direction_q};
          end
          cmpfl_pkg::ANALOG_STATUS_IDX: begin
            // Live bits are unsynchronised, sampled once here by intent
            prdata_o <= {28'h000_0000, live_two, live_one, flag_two, flag_one};
          end
          cmpfl_pkg::ANALOG_CONTROL_IDX: begin
            prdata_o <= {24'h00_0000, control_q};
          end
          cmpfl_pkg::ANALOG_SELECT_IDX: begin
            prdata_o <= {24'h00_0000, select_q};
          end
          cmpfl_pkg::PORT_B_DATA_IDX: begin
            prdata_o <= {24'h00_0000, port_data_q};
          end
          cmpfl_pkg::IRQ_MASK_IDX: begin
            prdata_o <= {30'h0000_0000, mask_q};
          end
          cmpfl_pkg::OPTION_IDX: begin
            prdata_o <= {31'h0000_0000, option_q};
          end
          default: begin
            // Pulldown inhibit is write only
            prdata_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog control and interrupts
  // ----------------------------------------------------------------
  // Bias follows either power enable; divider only with divider hold
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      analog_o <= '0;
    end else begin
      analog_o.pwr_one <= control_q[cmpfl_pkg::CT_PWR1];
      analog_o.pwr_two <= control_q[cmpfl_pkg::CT_PWR2];
      analog_o.bias_on <= control_q[cmpfl_pkg::CT_PWR1] | control_q[cmpfl_pkg::CT_PWR2];
      analog_o.invert <= select_q[cmpfl_pkg::SEL_INV];
      analog_o.divider_on <= select_q[cmpfl_pkg::SEL_DIVIDER_HOLD];
    end
  end

  // Level irq while an unmasked flag stands; capture from flag two when routed
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      analog_irq_o <= 1'b0;
      capture_trigger_o <= 1'b0;
    end else begin
      analog_irq_o <= (flag_one & mask_q[0]) | (flag_two & mask_q[1]);
      capture_trigger_o <= flag_two & control_q[cmpfl_pkg::CT_CAPT];
    end
  end

  // ----------------------------------------------------------------
  // Settle timer
  // ----------------------------------------------------------------
  // Restarts on power or flag change; limitation: models the typical figure only
  logic [$clog2(cmpfl_pkg::SETTLE_CYC+1)-1:0] settle_q;
  logic live_one_q;
  logic live_two_q;
  logic [1:0] pwr_q;
  logic restart;

  assign restart = (pwr_q != control_q[1:0]) || (live_one_q != flag_one) ||
                   (live_two_q != flag_two);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= '0;
      pwr_q <= 2'b00;
      live_one_q <= 1'b0;
      live_two_q <= 1'b0;
      settled_o <= 1'b0;
    end else begin
      pwr_q <= control_q[1:0];
      live_one_q <= flag_one;
      live_two_q <= flag_two;
      if (restart || control_q[1:0] == 2'b00) begin
        settle_q <= '0;
        settled_o <= 1'b0;
      end else if (settle_q < ($bits(settle_q))'(cmpfl_pkg::SETTLE_CYC)) begin
        settle_q <= settle_q + 1'b1;
        settled_o <= 1'b0;
      end else begin
        settled_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pin and pulldowns
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shared_output_pin_o <= 1'b0;
      shared_output_pin_oe_n_o <= 1'b1;
      pulldown_on_o <= 8'h00;
    end else begin
      shared_output_pin_o <= port_data_q[cmpfl_pkg::SHARED_BIT] | compare_output_level_i |
        (live_one & control_q[cmpfl_pkg::CT_PINEN] & option_q);
      shared_output_pin_oe_n_o <= ~direction_q[cmpfl_pkg::SHARED_BIT];
      // Output pins never pull down, whatever the inhibit says
      pulldown_on_o <= ~pd_inhibit_q & ~direction_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_irq_level;
    @(posedge clk_i) disable iff (!rst_n)
      (flag_one && mask_q[0]) |=> analog_irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing");

  property p_pd_off;
    @(posedge clk_i) disable iff (!rst_n)
      direction_q[cmpfl_pkg::SHARED_BIT] |=> !pulldown_on_o[cmpfl_pkg::SHARED_BIT];
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pulldown on output");

  property p_bias;
    @(posedge clk_i) disable iff (!rst_n)
      (control_q[1:0] != 2'b00) |=> analog_o.bias_on;
  endproperty
  a_bias: assert property (p_bias) else $error("bias off");

  property p_term_gate;
    @(posedge clk_i) disable iff (!rst_n)
      (!option_q && !port_data_q[cmpfl_pkg::SHARED_BIT] && !compare_output_level_i) |=>
        !shared_output_pin_o;
  endproperty
  a_term_gate: assert property (p_term_gate) else $error("ungated term");

  property p_flag_clear;
    @(posedge clk_i) disable iff (!rst_n)
      (clr_one && !u_flag_one.rise) |=> !flag_one;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag survived clear");

  property p_divider;
    @(posedge clk_i) disable iff (!rst_n)
      !select_q[cmpfl_pkg::SEL_DIVIDER_HOLD] |=> !analog_o.divider_on;
  endproperty
  a_divider: assert property (p_divider) else $error("divider on");

  property p_settle;
    @(posedge clk_i) disable iff (!rst_n)
      settled_o |-> settle_q == ($bits(settle_q))'(cmpfl_pkg::SETTLE_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("settle early");

  property p_capture;
    @(posedge clk_i) disable iff (!rst_n)
      (flag_two && control_q[cmpfl_pkg::CT_CAPT]) |=> capture_trigger_o;
  endproperty
  a_capture: assert property (p_capture) else $error("capture missing");
endmodule
`default_nettype wire

/* tb/cmpfl_top_tb.sv */
// Self-checking bench for the comparator flag and shared pin block
`timescale 1ns/1ps
`default_nettype none
module cmpfl_top_tb;
  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ST = cmpfl_pkg::ANALOG_STATUS_IDX;
  localparam logic [7:0] CT = cmpfl_pkg::ANALOG_CONTROL_IDX;
  localparam logic [7:0] SL = cmpfl_pkg::ANALOG_SELECT_IDX;
  localparam logic [7:0] DR = cmpfl_pkg::PORT_B_DIRECTION_IDX;
  localparam logic [32-1:0] CLR_BOTH = 32'h0000_0030; // Both flag clears
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic pready_o, pslverr_o, cmp_one_raw_i, cmp_two_raw_i, compare_output_level_i;
  cmpfl_pkg::cmpfl_analog_t analog_o;
  logic shared_output_pin_o, shared_output_pin_oe_n_o, analog_irq_o;
  logic capture_trigger_o, settled_o;
  logic [7:0] pulldown_on_o;
  int num_errors = 0;
  int total_checks = 0;

  cmpfl_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cmp_one_raw_i(cmp_one_raw_i),
    .cmp_two_raw_i(cmp_two_raw_i), .compare_output_level_i(compare_output_level_i),
    .analog_o(analog_o), .shared_output_pin_o(shared_output_pin_o),
    .shared_output_pin_oe_n_o(shared_output_pin_oe_n_o),
    .pulldown_on_o(pulldown_on_o), .analog_irq_o(analog_irq_o),
    .capture_trigger_o(capture_trigger_o), .settled_o(settled_o));

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Four-state compare, so an unknown never passes
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the slave decides how long the access lasts
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    // Values read here are those sampled at this edge
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    logic e;
    apb(1'b1, idx, wd, x, e);
    chk("write slverr", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] x);
    logic e;
    apb(1'b0, idx, 32'h0, x, e);
  endtask

  // Raw inputs change right after an edge, then wait past the sync stages
  task automatic raws(input logic a, input logic b);
    @(posedge clk_i);
    cmp_one_raw_i <= a;
    cmp_two_raw_i <= b;
    repeat (6) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic e;
    chk("oe_n reset", 32'h1, {31'h0, shared_output_pin_oe_n_o});
    chk("analog reset", 32'h0, {27'h0, analog_o});
    wr(DR, 32'h0000_00A5);
    rd(DR, r);
    chk("direction rw", 32'h0000_00A5, r);
    wr(DR, 32'h0);
    // Unmapped index answers with an error and zero data
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test regs done");
  endtask

  task automatic t_flags();
    raws(1'b1, 1'b0);
    rd(ST, r);
    chk("flag1 rise", 32'h0000_0005, r & 32'h0000_000F);
    raws(1'b0, 1'b0);
    rd(ST, r);
    chk("flag1 sticky", 32'h0000_0001, r & 32'h0000_000F);
    wr(ST, 32'h0000_0020);
    rd(ST, r);
    chk("flag1 other clear", 32'h0000_0001, r & 32'h0000_000F);
    wr(ST, 32'h0000_0010);
    rd(ST, r);
    chk("flag1 cleared", 32'h0, r & 32'h0000_000F);
    raws(1'b0, 1'b1);
    rd(ST, r);
    chk("flag2 rise", 32'h0000_000A, r & 32'h0000_000F);
    raws(1'b0, 1'b0);
    wr(ST, CLR_BOTH);
    $display("test flags done");
  endtask

  task automatic t_irq();
    raws(1'b1, 1'b0);
    wr(cmpfl_pkg::IRQ_MASK_IDX, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq unmasked", 32'h1, {31'h0, analog_irq_o});
    wr(cmpfl_pkg::IRQ_MASK_IDX, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, analog_irq_o});
    raws(1'b1, 1'b1);
    chk("irq flag2", 32'h1, {31'h0, analog_irq_o});
    chk("capture off", 32'h0, {31'h0, capture_trigger_o});
    wr(CT, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk("capture on", 32'h1, {31'h0, capture_trigger_o});
    wr(ST, CLR_BOTH);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, analog_irq_o});
    chk("capture cleared", 32'h0, {31'h0, capture_trigger_o});
    wr(CT, 32'h0);
    wr(cmpfl_pkg::IRQ_MASK_IDX, 32'h0);
    raws(1'b0, 1'b0);
    wr(ST, CLR_BOTH);
    $display("test irq done");
  endtask

  task automatic t_invert();
    wr(SL, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
    chk("invert out", 32'h1, {31'h0, analog_o.invert});
    wr(ST, CLR_BOTH);
    rd(ST, r);
    chk("live inverted", 32'h0000_000C, r & 32'h0000_000F);
    raws(1'b1, 1'b0);
    rd(ST, r);
    chk("fall no flag", 32'h0000_0008, r & 32'h0000_000F);
    raws(1'b0, 1'b0);
    rd(ST, r);
    chk("inverted rise", 32'h0000_000D, r & 32'h0000_000F);
    wr(SL, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("divider on", 32'h1, {31'h0, analog_o.divider_on});
    chk("invert off", 32'h0, {31'h0, analog_o.invert});
    wr(SL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("divider off", 32'h0, {31'h0, analog_o.divider_on});
    wr(ST, CLR_BOTH);
    $display("test invert done");
  endtask

  task automatic t_power();
    wr(CT, 32'h0000_0001);
    repeat (100) @(posedge clk_i);
    chk("power one", 32'h5, {29'h0, analog_o.pwr_one, analog_o.pwr_two, analog_o.bias_on});
    chk("not settled", 32'h0, {31'h0, settled_o});
    repeat (110) @(posedge clk_i);
    chk("settled", 32'h1, {31'h0, settled_o});
    // Software lets a freshly powered comparator stabilise before touching flags
    repeat (800) @(posedge clk_i);
    wr(CT, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("power two", 32'h3, {29'h0, analog_o.pwr_one, analog_o.pwr_two, analog_o.bias_on});
    wr(CT, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("power off", 32'h0, {29'h0, analog_o.pwr_one, analog_o.pwr_two, analog_o.bias_on});
    wr(ST, CLR_BOTH);
    $display("test power done");
  endtask

  task automatic t_pin();
    logic [4:0] v;
    wr(cmpfl_pkg::PULLDOWN_REG_IDX, 32'h0000_000F);
    wr(DR, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    chk("pulldown output", 32'h0000_00E0, {24'h0, pulldown_on_o});
    // Every combination of data, compare level, enable, option and comparator
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      wr(cmpfl_pkg::PORT_B_DATA_IDX, {27'h0, v[0], 4'h0});
      wr(CT, {28'h0, v[2], 3'b000});
      wr(cmpfl_pkg::OPTION_IDX, {31'h0, v[3]});
      @(posedge clk_i);
      compare_output_level_i <= v[1];
      cmp_one_raw_i <= v[4];
      repeat (6) @(posedge clk_i);
      chk("pin value", {31'h0, v[0] | v[1] | (v[2] & v[3] & v[4])}, {31'h0, shared_output_pin_o});
      chk("pin driving", 32'h0, {31'h0, shared_output_pin_oe_n_o});
    end
    wr(DR, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("pin released", 32'h1, {31'h0, shared_output_pin_oe_n_o});
    chk("pulldown input", 32'h0000_00F0, {24'h0, pulldown_on_o});
    $display("test pin done");
  endtask

  // ----------------------------------------------------------------
  // Verdict and sequencing
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    cmp_one_raw_i = 1'b0;
    cmp_two_raw_i = 1'b0;
    compare_output_level_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_flags();
    t_irq();
    t_invert();
    t_power();
    t_pin();
    end_of_test();
  end
endmodule
`default_nettype wire
